/* File: rtl/itm_clk_src.sv */
// counter clock source selection and input edge detection
`timescale 1ns/1ns
`include "itm_defines.svh"
module itm_clk_src (
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       sec_osc,
   input  wire logic       low_power_rc_osc_osc,
   input  wire logic       ded_pin,
   input  wire logic       gen_input,
   input  wire logic [1:0] ext_sel,
   input  wire logic       use_ext,
   input  wire logic       sync_en,
   output logic            tick
);
   itm_pkg::itm_src_state_t q;
   itm_pkg::itm_src_state_t d;
   logic                    raw;
   logic                    sampled;

   always_comb begin
      d = q;
      case (itm_pkg::itm_ext_src_t'(ext_sel))
         itm_pkg::SRC_GENERIC_INPUT: raw = gen_input;
         itm_pkg::SRC_LOW_POWER_RC:  raw = low_power_rc_osc_osc;
         itm_pkg::SRC_DEDICATED_PIN: raw = ded_pin;
         default:                    raw = sec_osc;
      endcase
      d.half  = ~q.half;
      d.sync1 = raw;
      d.sync2 = q.sync1;
      sampled = sync_en ? q.sync2 : raw;
      d.prev  = sampled;
      // internal half rate or rising edge of the chosen input
      tick = use_ext ? (sampled & ~q.prev) : q.half;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_half_rate: assert property (
      !use_ext && $past(!use_ext) ##0 tick ##1 !use_ext |-> !tick)
      else $error("internal tick faster than half rate");
   a_raw_edge: assert property (
      use_ext && !sync_en && $past(!sync_en) && raw && $past(!raw) |-> tick)
      else $error("unsynchronised edge missed");
endmodule

/* File: rtl/itm_defines.svh */
// register map, field positions, reset values and prescale limits
`ifndef ITM_DEFINES_SVH
`define ITM_DEFINES_SVH

`define ITM_ADDR_W        8
`define ITM_OFS_CTRL      8'h00
`define ITM_OFS_PERIOD    8'h04
`define ITM_OFS_COUNT     8'h08
`define ITM_OFS_STATUS    8'h0C
`define ITM_OFS_MASK      8'h10

`define ITM_CTRL_ON       15
`define ITM_CTRL_IDLE     13
`define ITM_CTRL_EXT_HI   9
`define ITM_CTRL_EXT_LO   8
`define ITM_CTRL_GATE     6
`define ITM_CTRL_PRE_HI   5
`define ITM_CTRL_PRE_LO   4
`define ITM_CTRL_SYNC     2
`define ITM_CTRL_CS       1
`define ITM_CTRL_WMASK    16'hA376

`define ITM_CTRL_RST      16'h0000
`define ITM_PERIOD_RST    16'hFFFF
`define ITM_COUNT_RST     16'h0000

`define ITM_EV_W          2
`define ITM_EV_MATCH      0
`define ITM_EV_GATE       1

`define ITM_PRE_W         8
`define ITM_PRE_LIM_1     8'h00
`define ITM_PRE_LIM_8     8'h07
`define ITM_PRE_LIM_64    8'h3F
`define ITM_PRE_LIM_256   8'hFF

`define ITM_RESP_OKAY     2'h0
`define ITM_RESP_SLVERR   2'h2

`endif

/* File: rtl/itm_pkg.sv */
// types shared by the interval timer modules
package itm_pkg;
`include "itm_defines.svh"

   typedef enum logic [1:0] {
      SRC_SECONDARY_OSC,
      SRC_DEDICATED_PIN,
      SRC_LOW_POWER_RC,
      SRC_GENERIC_INPUT
   } itm_ext_src_t;

   typedef enum logic [1:0] {
      PRE_DIV_1,
      PRE_DIV_8,
      PRE_DIV_64,
      PRE_DIV_256
   } itm_pre_sel_t;

   typedef struct packed {
      logic half;
      logic sync1;
      logic sync2;
      logic prev;
   } itm_src_state_t;

   typedef struct packed {
      logic [`ITM_PRE_W-1:0] cnt;
   } itm_pre_state_t;

   typedef struct packed {
      logic [15:0]             ctrl;
      logic [15:0]             period;
      logic [15:0]             count;
      logic [`ITM_EV_W-1:0]    status;
      logic [`ITM_EV_W-1:0]    mask;
      logic                    gate_prev;
      logic                    aw_got;
      logic                    w_got;
      logic [`ITM_ADDR_W-1:0]  awaddr;
      logic [31:0]             wdata;
      logic [3:0]              wstrb;
      logic                    awready;
      logic                    wready;
      logic                    bvalid;
      logic [1:0]              bresp;
      logic                    arready;
      logic                    rvalid;
      logic [31:0]             rdata;
      logic [1:0]              rresp;
      logic                    irq;
   } itm_top_state_t;

endpackage

/* File: rtl/itm_prescaler.sv */
// selectable input clock prescaler
`timescale 1ns/1ns
`include "itm_defines.svh"
module itm_prescaler (
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       clr,
   input  wire logic       tick_in,
   input  wire logic [1:0] sel,
   output logic            tick_out
);
   itm_pkg::itm_pre_state_t q;
   itm_pkg::itm_pre_state_t d;
   logic [`ITM_PRE_W-1:0]   lim;

   always_comb begin
      d = q;
      case (itm_pkg::itm_pre_sel_t'(sel))
         itm_pkg::PRE_DIV_256: lim = `ITM_PRE_LIM_256;
         itm_pkg::PRE_DIV_64:  lim = `ITM_PRE_LIM_64;
         itm_pkg::PRE_DIV_8:   lim = `ITM_PRE_LIM_8;
         default:              lim = `ITM_PRE_LIM_1;
      endcase
      tick_out = tick_in && !clr && (q.cnt >= lim);
      if (clr) begin
         d.cnt = '0;
      end else if (tick_in) begin
         d.cnt = (q.cnt >= lim) ? '0 : q.cnt + 8'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_pre_clear: assert property (clr |=> q.cnt == '0)
      else $error("prescale count not cleared");
   a_pre_div8: assert property (
      sel == 2'h1 && tick_out |=> !tick_out [*7])
      else $error("divide by eight ticks too early");
   a_pre_div1: assert property (
      sel == 2'h0 && tick_in && !clr |-> tick_out)
      else $error("divide by one dropped a tick");
endmodule

/* File: rtl/itm_timer_top.sv */
// 16-bit interval timer with AXI4-Lite registers and interrupt
//
// Contract
// - one 16-bit counter, timer or counter modes
// - interrupt on period match or gate fall
// - on bit starts and stops counting
// - idle-stop bit halts counting in idle
// - extended field picks one of four sources
// - internal clock is system clock halved
// - gate enable only with internal clock
// - prescaler divides by 1, 8, 64, 256
// - control write while running clears prescaler
// - sync bit synchronises external input
// - source select picks extended or internal
// - unimplemented control bits read zero
//
// Design decisions made here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
`include "itm_defines.svh"
module itm_timer_top (
   input  wire logic                   CLK,
   input  wire logic                   RESET,
   input  wire logic [`ITM_ADDR_W-1:0] S_AXI_AWADDR,
   input  wire logic                   S_AXI_AWVALID,
   output logic                        S_AXI_AWREADY,
   input  wire logic [31:0]            S_AXI_WDATA,
   input  wire logic [3:0]             S_AXI_WSTRB,
   input  wire logic                   S_AXI_WVALID,
   output logic                        S_AXI_WREADY,
   output logic [1:0]                  S_AXI_BRESP,
   output logic                        S_AXI_BVALID,
   input  wire logic                   S_AXI_BREADY,
   input  wire logic [`ITM_ADDR_W-1:0] S_AXI_ARADDR,
   input  wire logic                   S_AXI_ARVALID,
   output logic                        S_AXI_ARREADY,
   output logic [31:0]                 S_AXI_RDATA,
   output logic [1:0]                  S_AXI_RRESP,
   output logic                        S_AXI_RVALID,
   input  wire logic                   S_AXI_RREADY,
   input  wire logic                   SECONDARY_OSCILLATOR,
   input  wire logic                   LOW_POWER_RC_OSC,
   input  wire logic                   DEDICATED_EXT_CLOCK_PIN,
   input  wire logic                   GENERIC_EXT_TIMER_INPUT,
   input  wire logic                   GATE_IN,
   input  wire logic                   IDLE_MODE,
   output logic                        IRQ
);
   itm_pkg::itm_top_state_t q;
   itm_pkg::itm_top_state_t d;
   logic                    src_tick;
   logic                    pre_in;
   logic                    cnt_tick;
   logic                    cnt_en;
   logic                    gate_mode;
   logic                    wr_do;
   logic                    wr_ctrl;
   logic                    wr_cnt;
   logic                    pre_clr;
   logic                    ev_match;
   logic                    ev_gate;
   logic [`ITM_EV_W-1:0]    st_clr;

   function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                           input logic [15:0] new_v,
                                           input logic [1:0]  strb);
      merge16 = {strb[1] ? new_v[15:8] : old_v[15:8],
                 strb[0] ? new_v[7:0]  : old_v[7:0]};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // clock path

   // gating ignored when an extended source is chosen
   assign gate_mode = q.ctrl[`ITM_CTRL_GATE]
                      && !q.ctrl[`ITM_CTRL_CS];
   assign cnt_en    = q.ctrl[`ITM_CTRL_ON]
                      && !(q.ctrl[`ITM_CTRL_IDLE] && IDLE_MODE)
                      && (!gate_mode || GATE_IN);
   assign pre_in    = src_tick && cnt_en;

   itm_clk_src u_src (
      .clk       (CLK),
      .reset     (RESET),
      .sec_osc   (SECONDARY_OSCILLATOR),
      .low_power_rc_osc_osc  (LOW_POWER_RC_OSC),
      .ded_pin   (DEDICATED_EXT_CLOCK_PIN),
      .gen_input (GENERIC_EXT_TIMER_INPUT),
      .ext_sel   (q.ctrl[`ITM_CTRL_EXT_HI:`ITM_CTRL_EXT_LO]),
      .use_ext   (q.ctrl[`ITM_CTRL_CS]),
      .sync_en   (q.ctrl[`ITM_CTRL_SYNC]),
      .tick      (src_tick)
   );

   itm_prescaler u_pre (
      .clk      (CLK),
      .reset    (RESET),
      .clr      (pre_clr),
      .tick_in  (pre_in),
      .sel      (q.ctrl[`ITM_CTRL_PRE_HI:`ITM_CTRL_PRE_LO]),
      .tick_out (cnt_tick)
   );

   ////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      d        = q;
      wr_do    = q.aw_got && q.w_got && !q.bvalid;
      wr_ctrl  = 1'b0;
      wr_cnt   = 1'b0;
      ev_match = 1'b0;
      st_clr   = '0;
      // address and data may arrive in either order
      if (S_AXI_AWVALID && q.awready) begin
         d.aw_got = 1'b1;
         d.awaddr = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && q.wready) begin
         d.w_got = 1'b1;
         d.wdata = S_AXI_WDATA;
         d.wstrb = S_AXI_WSTRB;
      end
      if (wr_do) begin
         d.aw_got = 1'b0;
         d.w_got  = 1'b0;
         d.bvalid = 1'b1;
         d.bresp  = `ITM_RESP_OKAY;
         if (q.awaddr == `ITM_OFS_CTRL) begin
            d.ctrl  = merge16(q.ctrl, q.wdata[15:0], q.wstrb[1:0])
                      & `ITM_CTRL_WMASK;
            wr_ctrl = 1'b1;
         end else if (q.awaddr == `ITM_OFS_PERIOD) begin
            d.period = merge16(q.period, q.wdata[15:0], q.wstrb[1:0]);
         end else if (q.awaddr == `ITM_OFS_COUNT) begin
            wr_cnt = 1'b1;
         end else if (q.awaddr == `ITM_OFS_STATUS) begin
            if (q.wstrb[0]) begin
               st_clr = q.wdata[`ITM_EV_W-1:0];
            end
         end else if (q.awaddr == `ITM_OFS_MASK) begin
            if (q.wstrb[0]) begin
               d.mask = q.wdata[`ITM_EV_W-1:0];
            end
         end else begin
            d.bresp = `ITM_RESP_SLVERR;
         end
      end
      if (q.bvalid && S_AXI_BREADY) begin
         d.bvalid = 1'b0;
      end
      // one 16-bit counter for every mode
      if (wr_cnt) begin
         d.count = merge16(q.count, q.wdata[15:0], q.wstrb[1:0]);
      end else if (cnt_tick) begin
         if (q.count == q.period) begin
            d.count  = '0;
            ev_match = 1'b1;
         end else begin
            d.count = q.count + 16'h0001;
         end
      end
      d.gate_prev = GATE_IN;
      // set wins over a clear in the same cycle
      d.status = (q.status & ~st_clr)
                 | {ev_gate, ev_match};
      if (S_AXI_ARVALID && q.arready) begin
         d.rvalid = 1'b1;
         d.rresp  = `ITM_RESP_OKAY;
         if (S_AXI_ARADDR == `ITM_OFS_CTRL) begin
            d.rdata = {16'h0000, q.ctrl};
         end else if (S_AXI_ARADDR == `ITM_OFS_PERIOD) begin
            d.rdata = {16'h0000, q.period};
         end else if (S_AXI_ARADDR == `ITM_OFS_COUNT) begin
            d.rdata = {16'h0000, q.count};
         end else if (S_AXI_ARADDR == `ITM_OFS_STATUS) begin
            d.rdata = {30'h00000000, q.status};
         end else if (S_AXI_ARADDR == `ITM_OFS_MASK) begin
            d.rdata = {30'h00000000, q.mask};
         end else begin
            d.rdata = 32'h00000000;
            d.rresp = `ITM_RESP_SLVERR;
         end
      end else if (q.rvalid && S_AXI_RREADY) begin
         d.rvalid = 1'b0;
      end
      d.arready = !d.rvalid;
      d.awready = !d.aw_got && !d.bvalid;
      d.wready  = !d.w_got && !d.bvalid;
      d.irq     = |(d.status & d.mask);
   end

   // falling gate edge in gated mode
   assign ev_gate = gate_mode && q.gate_prev && !GATE_IN;
   // running control write restarts the prescaler
   assign pre_clr = wr_ctrl && q.ctrl[`ITM_CTRL_ON];

   always_ff @(posedge CLK) begin
      if (RESET) begin
         q        <= '0;
         q.ctrl   <= `ITM_CTRL_RST;
         q.period <= `ITM_PERIOD_RST;
         q.count  <= `ITM_COUNT_RST;
      end else begin
         q <= d;
      end
   end

   assign S_AXI_AWREADY = q.awready;
   assign S_AXI_WREADY  = q.wready;
   assign S_AXI_BVALID  = q.bvalid;
   assign S_AXI_BRESP   = q.bresp;
   assign S_AXI_ARREADY = q.arready;
   assign S_AXI_RVALID  = q.rvalid;
   assign S_AXI_RDATA   = q.rdata;
   assign S_AXI_RRESP   = q.rresp;
   assign IRQ           = q.irq;

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);

   a_off_holds: assert property (
      !q.ctrl[`ITM_CTRL_ON] && !wr_cnt |=> $stable(q.count))
      else $error("count moved while off");
   a_idle_halt: assert property (
      q.ctrl[`ITM_CTRL_IDLE] && IDLE_MODE && !wr_cnt |=> $stable(q.count))
      else $error("count moved in idle with stop set");
   a_match_wrap: assert property (
      cnt_tick && !wr_cnt && q.count == q.period
      |=> q.count == 16'h0000 && q.status[`ITM_EV_MATCH])
      else $error("period match did not wrap and flag");
   a_count_step: assert property (
      cnt_tick && !wr_cnt && q.count != q.period
      |=> q.count == $past(q.count) + 16'h0001)
      else $error("count did not step by one");
   a_gate_fall: assert property (
      gate_mode && q.gate_prev && !GATE_IN |=> q.status[`ITM_EV_GATE])
      else $error("gate fall not flagged");
   a_gate_block: assert property (
      gate_mode && !GATE_IN |-> !cnt_tick)
      else $error("counted with gate low");
   a_ext_nogate: assert property (
      q.ctrl[`ITM_CTRL_CS] |=> !q.status[`ITM_EV_GATE]
                               || $past(q.status[`ITM_EV_GATE]))
      else $error("gate event with extended source");
   a_unimpl_zero: assert property (
      (q.ctrl & ~`ITM_CTRL_WMASK) == 16'h0000)
      else $error("unimplemented control bit set");
   a_irq_level: assert property (
      IRQ == |(q.status & q.mask))
      else $error("interrupt level disagrees with status");
   a_write_resp: assert property (
      S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
      |=> ##1 S_AXI_BVALID)
      else $error("write response late");
   // bus answers hold until taken
   a_bresp_hold: assert property (
      S_AXI_BVALID && !S_AXI_BREADY
      |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
      else $error("write response dropped before taken");
   a_rdata_hold: assert property (
      S_AXI_RVALID && !S_AXI_RREADY
      |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
      else $error("read data dropped before taken");
   a_read_resp: assert property (
      S_AXI_ARVALID && S_AXI_ARREADY
      |=> S_AXI_RVALID && !S_AXI_ARREADY)
      else $error("read answer late");
   a_ready_busy: assert property (
      S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
      else $error("write accepted while response pending");
   a_bad_write: assert property (
      wr_do && q.awaddr != `ITM_OFS_CTRL && q.awaddr != `ITM_OFS_PERIOD
      && q.awaddr != `ITM_OFS_COUNT && q.awaddr != `ITM_OFS_STATUS
      && q.awaddr != `ITM_OFS_MASK
      |=> S_AXI_BRESP == `ITM_RESP_SLVERR)
      else $error("unmapped write not refused");

   // counter, flag, prescaler restart and gate checks
   a_count_load: assert property (
      wr_do && q.awaddr == `ITM_OFS_COUNT && q.wstrb[1:0] == 2'h3
      |=> q.count == $past(q.wdata[15:0]))
      else $error("count write lost");
   a_count_read: assert property (
      S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == `ITM_OFS_COUNT
      |=> S_AXI_RRESP == `ITM_RESP_OKAY
          && S_AXI_RDATA[15:0] == $past(q.count))
      else $error("count read wrong");
   a_flag_clear: assert property (
      st_clr[`ITM_EV_MATCH] && !ev_match |=> !q.status[`ITM_EV_MATCH])
      else $error("match flag not cleared");
   a_run_restart: assert property (
      wr_do && q.awaddr == `ITM_OFS_CTRL && q.ctrl[`ITM_CTRL_ON] |-> pre_clr)
      else $error("running control write kept prescale count");
   a_gate_ignored: assert property (
      q.ctrl[`ITM_CTRL_CS] && q.ctrl[`ITM_CTRL_ON]
      && !(q.ctrl[`ITM_CTRL_IDLE] && IDLE_MODE) |-> pre_in == src_tick)
      else $error("gate applied to extended source");

   c_match: cover property (ev_match);
   c_gate: cover property (ev_gate);
   c_run_write: cover property (pre_clr);
   c_read: cover property (S_AXI_RVALID && S_AXI_RREADY);
   c_idle: cover property (
      q.ctrl[`ITM_CTRL_IDLE] && IDLE_MODE && q.ctrl[`ITM_CTRL_ON]);
endmodule

/* File: sim/itm_src_model.sv */
// far-side model: four counter clock sources with rising-edge tallies
`timescale 1ns/1ns
module itm_src_model (
   input  wire logic        clk,
   input  wire logic        run,
   input  wire logic        clr,
   output logic [3:0]       src,
   output logic [15:0]      rises [4]
);
   logic [3:0]  lvl_q = 4'h0;
   logic [2:0]  ph_q [4] = '{3'h0, 3'h0, 3'h0, 3'h0};
   logic [15:0] cnt_q [4] = '{16'h0, 16'h0, 16'h0, 16'h0};
   assign src = lvl_q;
   assign rises = cnt_q;
   // half periods of 2 to 5 cycles; levels hold while stopped
   always @(posedge clk) begin
      for (int i = 0; i < 4; i++) begin
         if (clr) begin
            ph_q[i] <= 3'h0;
            cnt_q[i] <= 16'h0;
         end else if (run) begin
            if (ph_q[i] == 3'(i + 1)) begin
               ph_q[i] <= 3'h0;
               lvl_q[i] <= ~lvl_q[i];
               cnt_q[i] <= cnt_q[i] + 16'(!lvl_q[i]);
            end else begin
               ph_q[i] <= ph_q[i] + 3'h1;
            end
         end
      end
   end
endmodule

/* File: sim/itm_timer_top_bench.sv */
// self-checking bench for the interval timer
`timescale 1ns/1ns
module itm_timer_top_bench;
   logic        clk = 1'h0;
   logic        reset = 1'h1;
   logic [7:0]  awaddr = 8'h00;
   logic [7:0]  araddr = 8'h00;
   logic        awvalid = 1'h0;
   logic        wvalid = 1'h0;
   logic        bready = 1'h0;
   logic        arvalid = 1'h0;
   logic        rready = 1'h0;
   logic [31:0] wdata = 32'h0;
   logic [3:0]  wstrb = 4'hF;
   logic [1:0]  bresp, rresp, rsp;
   logic        awready, wready, bvalid, arready, rvalid, irq;
   logic [31:0] rdata, rdv, v;
   logic        gate = 1'h0;
   logic        idle = 1'h0;
   logic        run = 1'h0;
   logic        clr = 1'h1;
   logic [3:0]  src;
   logic [15:0] rises [4];
   logic [7:0]  ofs [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
   logic [31:0] rstv [5] = '{32'h0, 32'hFFFF, 32'h0, 32'h0, 32'h0};
   int          errors = 0;
   int          n_checks = 0;
   int          p, k, y;
   always #2 clk = ~clk;

   itm_src_model PART (.clk(clk), .run(run), .clr(clr), .src(src),
      .rises(rises));
   itm_timer_top DUT (.CLK(clk), .RESET(reset), .S_AXI_AWADDR(awaddr),
      .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
      .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
      .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
      .S_AXI_RREADY(rready), .SECONDARY_OSCILLATOR(src[0]),
      .DEDICATED_EXT_CLOCK_PIN(src[1]), .LOW_POWER_RC_OSC(src[2]),
      .GENERIC_EXT_TIMER_INPUT(src[3]), .GATE_IN(gate),
      .IDLE_MODE(idle), .IRQ(irq));

   ////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] ctrl_rd(input logic [31:0] d);
      return d & 32'h0000A376;
   endfunction
   function automatic int dv(input int s);
      return (s == 0) ? 1 : (s == 1) ? 8 : (s == 2) ? 64 : 256;
   endfunction
   function automatic logic [31:0] near(input logic [31:0] x,
                                        input int e, t);
      return {31'h0, !$isunknown(x) && int'(x) >= e - t
              && int'(x) <= e + t};
   endfunction

   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] s, e);
      n_checks++;
      if (s !== e) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic hang;
      errors++;
      $display("CHECK FAILED wait expected done seen timeout");
      finish_test();
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bit done;
      done = 1'b0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      for (int n = 0; n < 60 && !done; n++) begin
         @(posedge clk);
         if (awvalid && awready === 1'h1) awvalid <= 1'h0;
         if (wvalid && wready === 1'h1) wvalid <= 1'h0;
         if (bvalid === 1'h1) begin
            rsp = bresp;
            done = 1'b1;
         end
      end
      bready <= 1'h0;
      if (!done) hang();
   endtask
   task automatic rd(input logic [7:0] a);
      bit done;
      done = 1'b0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      for (int n = 0; n < 60 && !done; n++) begin
         @(posedge clk);
         if (arvalid && arready === 1'h1) arvalid <= 1'h0;
         if (rvalid === 1'h1) begin
            rdv = rdata;
            rsp = rresp;
            done = 1'b1;
         end
      end
      rready <= 1'h0;
      if (!done) hang();
   endtask

   ////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(83843));
      repeat (12) @(posedge clk);
      reset <= 1'h0;
      cyc(2);
      for (int i = 0; i < 5; i++) begin
         rd(ofs[i]);
         chk("reset value", rdv, rstv[i]);
      end
      wr(8'h00, 32'hFFFFFFFF);
      rd(8'h00);
      chk("ctrl bits", rdv, ctrl_rd(32'hFFFFFFFF));
      wr(8'h00, 32'h0);
      wr(8'h14, 32'h1);
      chk("bad write", {30'h0, rsp}, 32'h2);
      rd(8'h14);
      chk("bad read", {rdv[29:0], rsp}, 32'h2);
      v = {16'h0, 16'($urandom)};
      wr(8'h04, v);
      chk("write resp", {30'h0, rsp}, 32'h0);
      rd(8'h04);
      chk("read resp", {30'h0, rsp}, 32'h0);
      chk("period", rdv, v);
      $display("registers done");
      // internal half-rate clock through each prescale ratio
      wr(8'h04, 32'hFFFF);
      for (int s = 0; s < 4; s++) begin
         wr(8'h08, 32'h0);
         wr(8'h00, {16'h0, 16'h8000 | (16'(s) << 4)});
         cyc(40 * dv(s));
         wr(8'h00, 32'h0);
         rd(8'h08);
         chk("int count", near(rdv, 20, 2), 32'h1);
      end
      v = rdv;
      cyc(20);
      rd(8'h08);
      chk("stopped", rdv, v);
      $display("prescale done");
      // period match, flag, interrupt and its mask
      p = 3 + $urandom % 6;
      wr(8'h04, p);
      wr(8'h10, 32'h1);
      wr(8'h08, 32'h0);
      wr(8'h00, 32'h8000);
      for (k = 0; k < 200 && irq !== 1'h1; k++) @(posedge clk);
      if (irq !== 1'h1) hang();
      chk("match time", near(k, 2 * (p + 1), 4), 32'h1);
      wr(8'h00, 32'h0);
      rd(8'h0C);
      chk("match flag", rdv, 32'h1);
      rd(8'h08);
      chk("wrapped", near(rdv, 1, 2), 32'h1);
      wr(8'h0C, 32'h1);
      rd(8'h0C);
      chk("flag clear", rdv, 32'h0);
      chk("irq clear", {31'h0, irq}, 32'h0);
      wr(8'h10, 32'h0);
      wr(8'h00, 32'h8000);
      cyc(4 * p + 20);
      chk("masked irq", {31'h0, irq}, 32'h0);
      wr(8'h00, 32'h0);
      wr(8'h0C, 32'h3);
      $display("interrupt done");
      // idle stop
      wr(8'h04, 32'hFFFF);
      idle <= 1'h1;
      wr(8'h08, 32'h0);
      wr(8'h00, 32'hA000);
      cyc(40);
      rd(8'h08);
      chk("idle halt", rdv, 32'h0);
      wr(8'h00, 32'h8000);
      cyc(40);
      rd(8'h08);
      chk("idle run", {31'h0, rdv != 0}, 32'h1);
      wr(8'h00, 32'h0);
      idle <= 1'h0;
      $display("idle done");
      // gated accumulation
      wr(8'h08, 32'h0);
      wr(8'h00, 32'h8040);
      cyc(40);
      rd(8'h08);
      chk("gate low", rdv, 32'h0);
      gate <= 1'h1;
      cyc(40);
      gate <= 1'h0;
      cyc(4);
      rd(8'h08);
      chk("gate high", near(rdv, 20, 3), 32'h1);
      rd(8'h0C);
      chk("gate fall", rdv, 32'h2);
      wr(8'h00, 32'h0);
      wr(8'h0C, 32'h3);
      $display("gate done");
      // extended sources; the gate bit is set but must be ignored
      for (int s = 0; s < 4; s++) begin
         y = $urandom % 2;
         clr <= 1'h1;
         wr(8'h00, {16'h0, 16'h8042 | (16'(s) << 8) | (16'(y) << 2)});
         wr(8'h08, 32'h0);
         clr <= 1'h0;
         run <= 1'h1;
         cyc(40 + $urandom % 40);
         run <= 1'h0;
         cyc(8);
         rd(8'h08);
         chk("ext count", rdv, rises[s]);
      end
      // second control write while running clears the prescaler
      clr <= 1'h1;
      wr(8'h00, 32'h8112);
      wr(8'h00, 32'h8112);
      wr(8'h08, 32'h0);
      clr <= 1'h0;
      run <= 1'h1;
      cyc(200);
      run <= 1'h0;
      cyc(8);
      rd(8'h08);
      chk("ext by 8", rdv, rises[1] / 8);
      $display("external done");
      finish_test();
   end
endmodule
